/* design/host_port.sv */
// Host register access port with reset handling for a dual channel UART
`timescale 1ns/1ps
module host_port
    import hostport_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic              i_reset_high,
    input  wire logic              i_device_select_low,
    input  wire logic              i_write_strobe_low,
    input  wire logic              i_read_strobe_low,
    input  wire logic [ADDR_W-1:0] i_register_select_lines,
    input  wire logic [DATA_W-1:0] i_host_data_lines,
    input  wire logic [6:0]        i_input_port,
    input  wire logic [7:0]        i_irq_sources,
    output logic      [DATA_W-1:0] o_host_data_lines,
    output logic                   o_host_data_oe,
    output logic      [7:0]        o_general_output_pins,
    output logic                   o_serial_out_chan_a,
    output logic                   o_serial_out_chan_b,
    output logic                   o_interrupt_request_low,
    output logic                   o_interrupt_request_oe,
    output logic                   o_timer_running,
    output logic                   o_chan_a_active,
    output logic                   o_chan_b_active,
    output logic      [7:0]        o_output_port_config_reg,
    output logic      [7:0]        o_test_mode,
    output logic      [7:0]        o_rd_strobe_addr,
    output logic                   o_rd_strobe
);
    // ==========================================================
    // Reset and strobe qualification
    // ==========================================================
    wire any_reset = i_reset_high;
    wire wr_fall;
    wire wr_rise;
    wire rd_fall;
    wire rd_rise;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] wr_data_r;
    logic              wr_sel_r;

    strobe_edge u_wr_edge (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_level_n(i_write_strobe_low),
        .o_fall   (wr_fall),
        .o_rise   (wr_rise)
    );
    strobe_edge u_rd_edge (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_level_n(i_read_strobe_low),
        .o_fall   (rd_fall),
        .o_rise   (rd_rise)
    );

    // Address and data sampled while strobe is low; host keeps them stable
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_addr_r <= '0;
            wr_data_r <= RST_ZERO;
            wr_sel_r  <= 1'b0;
        end else if (!i_write_strobe_low) begin
            wr_addr_r <= i_register_select_lines;
            wr_data_r <= i_host_data_lines;
            wr_sel_r  <= ~i_device_select_low;
        end
    end

    // Commit on the rising edge of the write strobe
    wire wr_commit = wr_rise & wr_sel_r & ~any_reset;
    function automatic logic hit(input logic [3:0] a, input logic [3:0] code);
        hit = wr_commit && (a == code);
    endfunction

    // ==========================================================
    // Registers
    // ==========================================================
    // Mode registers survive the high reset; only the pointer returns
    logic [7:0] mode1_a_r;
    logic [7:0] mode2_a_r;
    logic [7:0] mode1_b_r;
    logic [7:0] mode2_b_r;
    logic       ptr_a_r;
    logic       ptr_b_r;
    logic [7:0] stat_a_r;
    logic [7:0] stat_b_r;
    logic [7:0] imask_r;
    logic [7:0] istat_r;
    logic [7:0] opr_r;
    logic [7:0] output_port_config_reg_r;
    logic [7:0] test_r;
    logic [7:0] ctu_r;
    logic [7:0] ctl_r;
    logic       tx_en_a_r;
    logic       tx_en_b_r;
    logic       ct_run_r;
    logic [7:0] hold_a_r;
    logic [7:0] hold_b_r;

    wire rd_start = rd_fall & ~i_device_select_low;
    wire rd_mode_a = rd_start && i_register_select_lines == A_MODE_A;
    wire rd_mode_b = rd_start && i_register_select_lines == A_MODE_B;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            {mode1_a_r, mode2_a_r, mode1_b_r, mode2_b_r} <= '0;
            {ctu_r, ctl_r, hold_a_r, hold_b_r} <= '0;
        end else begin
            if (hit(wr_addr_r, A_MODE_A) && !ptr_a_r) mode1_a_r <= wr_data_r;
            if (hit(wr_addr_r, A_MODE_A) && ptr_a_r)  mode2_a_r <= wr_data_r;
            if (hit(wr_addr_r, A_MODE_B) && !ptr_b_r) mode1_b_r <= wr_data_r;
            if (hit(wr_addr_r, A_MODE_B) && ptr_b_r)  mode2_b_r <= wr_data_r;
            if (hit(wr_addr_r, A_CTUR))   ctu_r    <= wr_data_r;
            if (hit(wr_addr_r, A_CTLR))   ctl_r    <= wr_data_r;
            if (hit(wr_addr_r, A_DATA_A)) hold_a_r <= wr_data_r;
            if (hit(wr_addr_r, A_DATA_B)) hold_b_r <= wr_data_r;
        end
    end

    // Registers cleared by the high reset level
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            {stat_a_r, stat_b_r, imask_r, istat_r, opr_r, output_port_config_reg_r} <= '0;
            {test_r, ptr_a_r, ptr_b_r, tx_en_a_r, tx_en_b_r, ct_run_r} <= '0;
        end else if (any_reset) begin
            {stat_a_r, stat_b_r, imask_r, istat_r, opr_r, output_port_config_reg_r} <= '0;
            test_r   <= RST_ZERO;
            ptr_a_r  <= 1'b0;
            ptr_b_r  <= 1'b0;
            tx_en_a_r <= 1'b0;
            tx_en_b_r <= 1'b0;
            ct_run_r <= 1'b0;
        end else begin
            if (hit(wr_addr_r, A_IMASK)) imask_r <= wr_data_r;
            if (hit(wr_addr_r, A_OUTPUT_PORT_CONFIG_REG))  output_port_config_reg_r  <= wr_data_r;
            if (hit(wr_addr_r, A_TEST))  test_r  <= wr_data_r;
            if (hit(wr_addr_r, A_OP_SET)) opr_r  <= opr_r | wr_data_r;
            if (hit(wr_addr_r, A_OP_CLR)) opr_r  <= opr_r & ~wr_data_r;
            // Pointer advances once per mode access, sticks on the second
            if (hit(wr_addr_r, A_MODE_A) || rd_mode_a) ptr_a_r <= 1'b1;
            if (hit(wr_addr_r, A_MODE_B) || rd_mode_b) ptr_b_r <= 1'b1;
            if (hit(wr_addr_r, A_CMD_A)) begin
                if (wr_data_r[CMD_TX_EN])  tx_en_a_r <= 1'b1;
                if (wr_data_r[CMD_TX_DIS]) tx_en_a_r <= 1'b0;
            end
            if (hit(wr_addr_r, A_CMD_B)) begin
                if (wr_data_r[CMD_TX_EN])  tx_en_b_r <= 1'b1;
                if (wr_data_r[CMD_TX_DIS]) tx_en_b_r <= 1'b0;
            end
            stat_a_r[ST_TXRDY] <= tx_en_a_r;
            stat_a_r[ST_TXEMT] <= tx_en_a_r;
            stat_b_r[ST_TXRDY] <= tx_en_b_r;
            stat_b_r[ST_TXEMT] <= tx_en_b_r;
            // Sticky set wins over nothing here; sources are levels
            istat_r <= i_irq_sources;
            if (rd_start && i_register_select_lines == A_CT_START) ct_run_r <= 1'b1;
            if (rd_start && i_register_select_lines == A_CT_STOP)  ct_run_r <= 1'b0;
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    logic [7:0] rd_mux;
    always_comb begin
        case (i_register_select_lines)
            A_MODE_A: rd_mux = ptr_a_r ? mode2_a_r : mode1_a_r;
            A_STAT_A: rd_mux = stat_a_r;
            A_DATA_A: rd_mux = hold_a_r;
            A_IMASK:  rd_mux = istat_r;
            A_CTUR:   rd_mux = ctu_r;
            A_CTLR:   rd_mux = ctl_r;
            A_MODE_B: rd_mux = ptr_b_r ? mode2_b_r : mode1_b_r;
            A_STAT_B: rd_mux = stat_b_r;
            A_DATA_B: rd_mux = hold_b_r;
            A_INPORT: rd_mux = {1'b0, i_input_port};
            default:  rd_mux = RST_ZERO;
        endcase
    end

    // Latched at read start, so a pointer step cannot change it mid-read
    logic [7:0] dout_r;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            dout_r <= RST_ZERO;
        end else if (rd_start) begin
            dout_r <= rd_mux;
        end
    end

    // Drive only while select and read are low and write is idle; release is immediate
    wire bus_drive = ~i_device_select_low & ~i_read_strobe_low & i_write_strobe_low;
    assign o_host_data_oe    = bus_drive & ~i_device_select_low;
    assign o_host_data_lines = dout_r;

    // ==========================================================
    // Pins
    // ==========================================================
    wire loop_a = mode2_a_r[7:6] == CHMODE_LOOP;
    wire loop_b = mode2_b_r[7:6] == CHMODE_LOOP;
    // No serializer here, so an enabled channel idles too
    assign o_serial_out_chan_a = 1'b1;
    assign o_serial_out_chan_b = 1'b1;
    assign o_general_output_pins = ~opr_r;
    // Open drain: the pin is pulled low only while its enable is high
    wire irq_any = |(istat_r & imask_r);
    assign o_interrupt_request_low = 1'b0;
    assign o_interrupt_request_oe  = irq_any;
    assign o_timer_running          = ct_run_r;
    assign o_chan_a_active          = tx_en_a_r & ~loop_a;
    assign o_chan_b_active          = tx_en_b_r & ~loop_b;
    assign o_output_port_config_reg = output_port_config_reg_r;
    assign o_test_mode              = test_r;
    // Read-start strobe and address for the blocks behind the port
    assign o_rd_strobe_addr         = {4'h0, i_register_select_lines};
    assign o_rd_strobe              = rd_start;
    // Edges kept for symmetry; nothing acts on them yet
    wire unused = rd_rise ^ wr_fall;
endmodule // host_port

/* design/strobe_edge.sv */
// Synchronous edge detector for active-low host strobes
`timescale 1ns/1ps
module strobe_edge (
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic i_level_n,
    output logic      o_fall,
    output logic      o_rise
);
    logic prev_r;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= i_level_n;
        end
    end

    assign o_fall = prev_r & ~i_level_n;
    assign o_rise = ~prev_r & i_level_n;
endmodule // strobe_edge

/* pkg/hostport_pkg.sv */
// Constants and register map for the host register access port
//
// Function
// - Select low enables byte transfers on bus
// - Select high floats all eight data lines
// - Write captured at write strobe rising edge
// - Read drives addressed register onto bus
// - Read strobe falling edge starts read cycle
// - Four-bit select decodes registers and ports
// - Eight-bit bus, line zero is LSB
// - Reset clears status, mask, port registers
// - Reset drives all general outputs high
// - Reset halts timer, channels go inactive
// - Transmit outputs held at mark after reset
// - Reset clears test modes, pointer to first
// - Transmit stays mark when disabled or looped
// - Interrupt request low, open drain, masked OR
package hostport_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    // Register select codes
    localparam logic [3:0] A_MODE_A   = 4'h0;
    localparam logic [3:0] A_STAT_A   = 4'h1;
    localparam logic [3:0] A_CMD_A    = 4'h2;
    localparam logic [3:0] A_DATA_A   = 4'h3;
    localparam logic [3:0] A_OUTPUT_PORT_CONFIG_REG     = 4'h4;
    localparam logic [3:0] A_IMASK    = 4'h5;
    localparam logic [3:0] A_CTUR     = 4'h6;
    localparam logic [3:0] A_CTLR     = 4'h7;
    localparam logic [3:0] A_MODE_B   = 4'h8;
    localparam logic [3:0] A_STAT_B   = 4'h9;
    localparam logic [3:0] A_CMD_B    = 4'ha;
    localparam logic [3:0] A_DATA_B   = 4'hb;
    localparam logic [3:0] A_TEST     = 4'hc;
    localparam logic [3:0] A_INPORT   = 4'hd;
    localparam logic [3:0] A_OP_SET   = 4'he;
    localparam logic [3:0] A_OP_CLR   = 4'hf;
    // Reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_BYTE1  = 8'h01;
    // Command field: bit 2 tx enable, bit 3 tx disable, bits 6:4 misc
    localparam int CMD_TX_EN  = 2;
    localparam int CMD_TX_DIS = 3;
    // Mode byte two: bits 7:6 channel mode, 2'b10 is local loopback
    localparam logic [1:0] CHMODE_LOOP = 2'h2;
    // Status bits for transmitter ready and transmitter empty
    localparam int ST_TXRDY = 2;
    localparam int ST_TXEMT = 3;
    // Counter start/stop reads by register select
    localparam logic [3:0] A_CT_START = 4'he;
    localparam logic [3:0] A_CT_STOP  = 4'hf;
endpackage : hostport_pkg

/* tb/host_bus_model.sv */
// Behavioural host processor driving the register port strobes
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rd_data,
    output logic            o_select_n,
    output logic            o_write_n,
    output logic            o_read_n,
    output logic      [3:0] o_addr,
    output logic      [7:0] o_wr_data,
    output logic      [7:0] o_got,
    output logic            o_got_vld
);
    initial begin
        o_select_n = 1'b1;
        o_write_n  = 1'b1;
        o_read_n   = 1'b1;
        o_addr     = 4'h0;
        o_wr_data  = 8'h00;
        o_got      = 8'h00;
        o_got_vld  = 1'b0;
    end
    // =========================
    // Bus cycles, hold sets the strobe width
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input int hold);
        @(posedge i_mclk);
        o_select_n <= 1'b0;
        o_write_n  <= 1'b0;
        o_addr     <= a;
        o_wr_data  <= d;
        repeat (hold) @(posedge i_mclk);
        o_write_n  <= 1'b1;
        @(posedge i_mclk);
        o_select_n <= 1'b1;
        // Released lines show the inverted last value, never the last value itself
        o_addr     <= ~a;
        o_wr_data  <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, input int hold);
        @(posedge i_mclk);
        o_select_n <= 1'b0;
        o_read_n   <= 1'b0;
        o_addr     <= a;
        repeat (hold) @(posedge i_mclk);
        o_got      <= i_rd_data;
        o_got_vld  <= 1'b1;
        o_read_n   <= 1'b1;
        o_select_n <= 1'b1;
        o_addr     <= ~a;
        @(posedge i_mclk);
        o_got_vld  <= 1'b0;
    endtask
endmodule // host_bus_model

/* tb/host_port_bench.sv */
// Self-checking bench for the host register port
`timescale 1ns/1ps
module host_port_bench
    import hostport_pkg::*;
;
    logic i_mclk = 1'b0, i_resetn = 1'b0, i_reset_high = 1'b0, o_host_data_oe, got_vld;
    logic i_device_select_low, i_write_strobe_low, i_read_strobe_low, o_rd_strobe;
    logic o_serial_out_chan_a, o_serial_out_chan_b, o_interrupt_request_low;
    logic o_interrupt_request_oe, o_timer_running, o_chan_a_active, o_chan_b_active;
    logic [3:0] i_register_select_lines;
    logic [6:0] i_input_port = 7'h00;
    logic [7:0] i_irq_sources = 8'h00, i_host_data_lines, o_host_data_lines, host_d, got, v;
    logic [7:0] o_general_output_pins, o_output_port_config_reg, o_test_mode, o_rd_strobe_addr;
    logic [15:0] n;
    logic [15:0] exp_q[$];
    int err_count = 0;
    int tests_run = 0;
    always #25 i_mclk = ~i_mclk;
    host_port u_dut (.*);
    host_bus_model u_host (.i_mclk(i_mclk), .i_rd_data(i_host_data_lines),
        .o_select_n(i_device_select_low), .o_write_n(i_write_strobe_low),
        .o_read_n(i_read_strobe_low), .o_addr(i_register_select_lines),
        .o_wr_data(host_d), .o_got(got), .o_got_vld(got_vld));
    assign i_host_data_lines = o_host_data_oe ? o_host_data_lines : host_d;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("err_count=%0d tests_run=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(posedge i_mclk);
        #1;
    endtask
    // =========================
    // Read results against the oldest note
    always @(posedge i_mclk) begin
        if (got_vld) begin
            if (exp_q.size() == 0) exp_q.push_back({8'hff, ~got});
            n = exp_q.pop_front();
            chk(got & n[15:8], n[7:0]);
        end
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        $display("MISMATCH t=%0t run timed out", $time);
        err_count++;
        final_report();
    end
    initial begin
        void'($urandom(63));
        repeat (8) @(posedge i_mclk);
        i_resetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            u_host.wr(A_OUTPUT_PORT_CONFIG_REG, v, 1 + i % 3);
            settle();
            chk(o_output_port_config_reg, v);
        end
        u_host.wr(A_TEST, ~v, 3);
        u_host.wr(A_OP_SET, v, 1);
        settle();
        chk(o_test_mode, ~v);
        chk(o_general_output_pins, ~v);
        u_host.wr(A_OP_CLR, 8'h0f, 2);
        i_input_port <= 7'($urandom);
        i_irq_sources <= 8'h01 << ($urandom % 8);
        u_host.wr(A_IMASK, 8'hff, 1);
        u_host.wr(A_CMD_A, 8'h04, 1);
        u_host.wr(A_CMD_B, 8'h04, 1);
        settle();
        chk(o_general_output_pins, ~v | 8'h0f);
        chk({4'h0, o_interrupt_request_oe, o_interrupt_request_low, o_chan_a_active,
             o_chan_b_active}, 8'h0b);
        exp_q.push_back({8'hff, 1'b0, i_input_port});
        u_host.rd(A_INPORT, 2);
        // First mode write lands in mode one, the pointer then sticks on two
        u_host.wr(A_MODE_A, 8'h13, 1);
        u_host.wr(A_MODE_A, 8'h80, 2);
        exp_q.push_back({8'hff, 8'h80});
        u_host.rd(A_MODE_A, 2);
        u_host.wr(A_CMD_B, 8'h08, 1);
        settle();
        chk({6'h0, o_chan_a_active, o_chan_b_active}, 8'h00);
        exp_q.push_back({8'hff, 8'h00});
        u_host.rd(A_CT_START, 3);
        settle();
        chk({7'h0, o_timer_running}, 8'h01);
        exp_q.push_back({8'hff, 8'h00});
        u_host.rd(A_CT_STOP, 2);
        settle();
        chk({7'h0, o_timer_running}, 8'h00);
        exp_q.push_back({8'hff, 8'h00});
        u_host.rd(A_CT_START, 2);
        settle();
        chk({7'h0, o_timer_running}, 8'h01);
        i_reset_high <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_reset_high <= 1'b0;
        settle();
        chk(o_general_output_pins, 8'hff);
        chk(o_output_port_config_reg, 8'h00);
        chk(o_test_mode, 8'h00);
        chk({4'h0, o_timer_running, o_chan_a_active, o_chan_b_active,
             o_interrupt_request_oe}, 8'h00);
        chk({6'h0, o_serial_out_chan_a, o_serial_out_chan_b}, 8'h03);
        exp_q.push_back({8'hff, 8'h13});
        u_host.rd(A_MODE_A, 2);
        settle();
        if (exp_q.size() != 0) begin
            $display("MISMATCH t=%0t %0d reads never answered", $time, exp_q.size());
            err_count++;
        end
        final_report();
    end
endmodule // host_port_bench

/* tb/host_port_chk.sv */
// Concurrent checks on the host port pins
`timescale 1ns/1ps
module host_port_chk
    import hostport_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_resetn,
    input wire logic        i_reset_high,
    input wire logic        i_device_select_low,
    input wire logic        i_write_strobe_low,
    input wire logic        i_read_strobe_low,
    input wire logic [3:0]  i_register_select_lines,
    input wire logic [7:0]  i_host_data_lines,
    input wire logic        o_host_data_oe,
    input wire logic [7:0]  o_general_output_pins,
    input wire logic        o_serial_out_chan_a,
    input wire logic        o_serial_out_chan_b,
    input wire logic        o_interrupt_request_oe,
    input wire logic        o_timer_running,
    input wire logic        o_chan_a_active,
    input wire logic        o_chan_b_active,
    input wire logic [7:0]  o_output_port_config_reg,
    input wire logic [7:0]  o_test_mode,
    input wire logic        o_rd_strobe
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    AST_OE_SEL: assert property (i_device_select_low |-> !o_host_data_oe)
        else $error("data bus driven while deselected");
    AST_OE_RD: assert property (!i_device_select_low && !i_read_strobe_low
        && i_write_strobe_low |-> o_host_data_oe) else $error("read not driven");
    AST_OE_REL: assert property (i_read_strobe_low |-> !o_host_data_oe)
        else $error("bus held after read");
    AST_RD_START: assert property ($fell(i_read_strobe_low) && !i_device_select_low
        |-> ##[0:2] o_rd_strobe) else $error("read start missed");
    AST_RD_ONE: assert property (o_rd_strobe |=> !o_rd_strobe)
        else $error("read start not a pulse");
    AST_PINS: assert property (i_reset_high |=> o_general_output_pins == 8'hff)
        else $error("outputs not high in reset");
    AST_RST_CLR: assert property (i_reset_high |=> o_output_port_config_reg == 8'h00
        && o_test_mode == 8'h00 && !o_timer_running && !o_chan_a_active
        && !o_chan_b_active) else $error("reset left state set");
    AST_IRQ: assert property (i_reset_high [*2] |=> !o_interrupt_request_oe)
        else $error("interrupt after reset");
    AST_TX: assert property (o_serial_out_chan_a && o_serial_out_chan_b)
        else $error("transmit line left mark");
    AST_WR_CFG: assert property ($rose(i_write_strobe_low) && !i_device_select_low
        && i_register_select_lines == A_OUTPUT_PORT_CONFIG_REG && !i_reset_high
        |-> (##1 o_output_port_config_reg == $past(i_host_data_lines))
        or (##2 o_output_port_config_reg == $past(i_host_data_lines, 2)))
        else $error("config write not applied");
endmodule // host_port_chk
bind host_port host_port_chk u_chk (.*);
